// file: hw/rsc_divider_select.sv
// preset divider lookup from strap pins with per-divider override inputs
`timescale 1ns/1ns
`default_nettype none
module rsc_divider_select
  import rsc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [SEL_W-1:0] sel_a,
  input  wire logic [SEL_W-1:0] sel_b,
  input  wire logic [SEL_W-1:0] sel_y,
  input  wire logic             ovr_a_en,
  input  wire logic [DIV_W-1:0] ovr_a_val,
  input  wire logic             ovr_b_en,
  input  wire logic [DIV_W-1:0] ovr_b_val,
  input  wire logic             ovr_y_en,
  input  wire logic [DIV_W-1:0] ovr_y_val,
  output logic [DIV_W-1:0]      div_a,
  output logic [DIV_W-1:0]      div_b,
  output logic [DIV_W-1:0]      div_y,
  output logic                  sel_valid
);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_a     <= DIV_RST;
      div_b     <= DIV_RST;
      div_y     <= DIV_RST;
      sel_valid <= 1'b0;
    end else begin
      div_a     <= ovr_a_en ? ovr_a_val : rsc_in_div(sel_a);
      div_b     <= ovr_b_en ? ovr_b_val : rsc_in_div(sel_b);
      div_y     <= ovr_y_en ? ovr_y_val : rsc_out_div(sel_y);
      // 15 input codes usable, all 16 output codes usable
      sel_valid <= (ovr_a_en || sel_a != IN_SEL_RESERVED) &&
                   (ovr_b_en || sel_b != IN_SEL_RESERVED);
    end
  end
endmodule
`default_nettype wire

// file: hw/rsc_pkg.sv
// constants and types for the reference switchover control
package rsc_pkg;
  localparam int unsigned SEL_W         = 4;
  localparam int unsigned DIV_W         = 16;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned LOSS_TIME_NS  = 1000;
  localparam int unsigned LOSS_CYC      = (LOSS_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned ALIGN_TIME_NS = 200;
  localparam int unsigned ALIGN_CYC     = (ALIGN_TIME_NS * CLK_MHZ) / 1000;
  localparam logic [SEL_W-1:0] IN_SEL_RESERVED = 4'hF;
  localparam logic [DIV_W-1:0] DIV_RST  = 16'h0001;

  typedef enum logic [3:0] {
    RSC_ST_IDLE     = 4'h1,
    RSC_ST_ACTIVE0  = 4'h2,
    RSC_ST_ACTIVE1  = 4'h4,
    RSC_ST_HOLDOVER = 4'h8
  } rsc_state_t;

  // preset divider tables: input code sets the input divider, output code the output divider
  function automatic logic [DIV_W-1:0] rsc_in_div(input logic [SEL_W-1:0] code);
    rsc_in_div = DIV_W'({12'h000, code} + 16'h0001);
  endfunction

  function automatic logic [DIV_W-1:0] rsc_out_div(input logic [SEL_W-1:0] code);
    rsc_out_div = DIV_W'({12'h000, code} * 16'h0002 + 16'h0002);
  endfunction
endpackage

// file: hw/rsc_ref_monitor.sv
// activity monitor for one reference input, run on the oscillator clock
`timescale 1ns/1ns
`default_nettype none
module rsc_ref_monitor
  import rsc_pkg::*;
#(
  parameter int unsigned LOSS_CYCLES = LOSS_CYC
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ref_in,
  output logic      present,
  output logic      edge_seen
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic [15:0] idle_cnt_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= ref_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign edge_seen = sync2_reg & ~prev_reg;

  // presence is decided from edges alone, no software involved
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      idle_cnt_reg <= 16'h0000;
      present      <= 1'b0;
    end else if (edge_seen) begin
      idle_cnt_reg <= 16'h0000;
      present      <= 1'b1;
    end else if (idle_cnt_reg >= 16'(LOSS_CYCLES - 1)) begin
      present <= 1'b0;
    end else begin
      idle_cnt_reg <= idle_cnt_reg + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// file: hw/rsc_switchover.sv
// top: reference monitoring, active/backup selection, alignment and holdover
`timescale 1ns/1ns
`default_nettype none
module rsc_switchover
  import rsc_pkg::*;
#(
  parameter int unsigned LOSS_CYCLES  = LOSS_CYC,
  parameter int unsigned ALIGN_CYCLES = ALIGN_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ref0_in,
  input  wire logic             ref1_in,
  input  wire logic [SEL_W-1:0] sel_a,
  input  wire logic [SEL_W-1:0] sel_b,
  input  wire logic [SEL_W-1:0] sel_y,
  input  wire logic             ovr_a_en,
  input  wire logic [DIV_W-1:0] ovr_a_val,
  input  wire logic             ovr_b_en,
  input  wire logic [DIV_W-1:0] ovr_b_val,
  input  wire logic             ovr_y_en,
  input  wire logic [DIV_W-1:0] ovr_y_val,
  output logic                  ref0_present,
  output logic                  ref1_present,
  output logic                  active_sel,
  output logic                  active_valid,
  output logic                  backup_valid,
  output logic                  backup_aligned,
  output logic                  holdover,
  output logic                  switch_pulse,
  output logic [DIV_W-1:0]      div_a,
  output logic [DIV_W-1:0]      div_b,
  output logic [DIV_W-1:0]      div_y,
  output logic                  sel_valid
);
  rsc_state_t state_reg;
  rsc_state_t state_next;
  logic       pres0;
  logic       pres1;
  logic       edge0;
  logic       edge1;
  logic       edge_act;
  logic       edge_bak;
  logic       bak_pres;
  logic [15:0] phase_cnt_reg;
  logic       align_reg;
  logic       bak_pres_reg;

  // decode helpers shared by the active_valid and switch pulse logic
  function automatic logic rsc_is_active(input rsc_state_t st);
    rsc_is_active = (st == RSC_ST_ACTIVE0) || (st == RSC_ST_ACTIVE1);
  endfunction

  function automatic logic rsc_is_swap(input rsc_state_t cur, input rsc_state_t nxt);
    rsc_is_swap = rsc_is_active(cur) && rsc_is_active(nxt) && (cur != nxt);
  endfunction

  // all monitoring clocked by the oscillator clock clk
  rsc_ref_monitor #(.LOSS_CYCLES(LOSS_CYCLES)) u_mon0 (
    .clk       (clk),
    .rst_b     (rst_b),
    .ref_in    (ref0_in),
    .present   (pres0),
    .edge_seen (edge0)
  );

  rsc_ref_monitor #(.LOSS_CYCLES(LOSS_CYCLES)) u_mon1 (
    .clk       (clk),
    .rst_b     (rst_b),
    .ref_in    (ref1_in),
    .present   (pres1),
    .edge_seen (edge1)
  );

  rsc_divider_select u_div (
    .clk       (clk),
    .rst_b     (rst_b),
    .sel_a     (sel_a),
    .sel_b     (sel_b),
    .sel_y     (sel_y),
    .ovr_a_en  (ovr_a_en),
    .ovr_a_val (ovr_a_val),
    .ovr_b_en  (ovr_b_en),
    .ovr_b_val (ovr_b_val),
    .ovr_y_en  (ovr_y_en),
    .ovr_y_val (ovr_y_val),
    .div_a     (div_a),
    .div_b     (div_b),
    .div_y     (div_y),
    .sel_valid (sel_valid)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RSC_ST_IDLE, RSC_ST_HOLDOVER: begin
        // ref0 wins a tie; from holdover whichever returns first
        if (pres0) begin
          state_next = RSC_ST_ACTIVE0;
        end else if (pres1) begin
          state_next = RSC_ST_ACTIVE1;
        end else if (state_reg == RSC_ST_IDLE) begin
          state_next = RSC_ST_IDLE;
        end
      end
      RSC_ST_ACTIVE0: begin
        if (!pres0) begin
          state_next = pres1 ? RSC_ST_ACTIVE1 : RSC_ST_HOLDOVER;
        end
      end
      RSC_ST_ACTIVE1: begin
        if (!pres1) begin
          state_next = pres0 ? RSC_ST_ACTIVE0 : RSC_ST_HOLDOVER;
        end
      end
      default: state_next = RSC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= RSC_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign edge_act = (state_reg == RSC_ST_ACTIVE1) ? edge1 : edge0;
  assign edge_bak = (state_reg == RSC_ST_ACTIVE1) ? edge0 : edge1;
  assign bak_pres = (state_reg == RSC_ST_ACTIVE0) ? pres1 :
                    (state_reg == RSC_ST_ACTIVE1) ? pres0 : 1'b0;

  // alignment: backup edges must fall within the window after an active edge;
  // cycles since the last active edge, parked at all ones so it never wraps
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phase_cnt_reg <= 16'hFFFF;
    end else if (edge_act) begin
      phase_cnt_reg <= 16'h0000;
    end else if (phase_cnt_reg != 16'hFFFF) begin
      phase_cnt_reg <= phase_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bak_pres_reg <= 1'b0;
    end else begin
      bak_pres_reg <= bak_pres;
    end
  end

  // a returning backup starts unaligned and must requalify
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      align_reg <= 1'b0;
    end else if (!bak_pres || !bak_pres_reg || state_reg != state_next) begin
      align_reg <= 1'b0;
    end else if (edge_bak) begin
      align_reg <= edge_act || (phase_cnt_reg < 16'(ALIGN_CYCLES));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ref0_present <= 1'b0;
      ref1_present <= 1'b0;
    end else begin
      ref0_present <= pres0;
      ref1_present <= pres1;
    end
  end

  // selection follows this cycle's decision so it lines up with presence
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      active_sel   <= 1'b0;
      active_valid <= 1'b0;
    end else begin
      active_sel   <= (state_next == RSC_ST_ACTIVE1);
      active_valid <= rsc_is_active(state_next);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      backup_valid   <= 1'b0;
      backup_aligned <= 1'b0;
    end else begin
      backup_valid   <= bak_pres && (state_reg == state_next);
      backup_aligned <= align_reg;
    end
  end

  // output PLL keeps running from the oscillator while this is high
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      holdover <= 1'b0;
    end else begin
      holdover <= (state_next == RSC_ST_HOLDOVER);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      switch_pulse <= 1'b0;
    end else begin
      switch_pulse <= rsc_is_swap(state_reg, state_next);
    end
  end
endmodule
`default_nettype wire

// file: verification/reference_switchover_control_test.sv
// self-checking bench for the reference switchover top
`timescale 1ns/1ns
`default_nettype none
module reference_switchover_control_test;
  import rsc_pkg::*;
  typedef struct {logic k; logic [48:0] m; logic [48:0] v;} rsc_note_t;
  logic             clk = 1'h0;
  logic             rst_b = 1'h0;
  logic             en0 = 1'h0;
  logic             en1 = 1'h0;
  logic             ref0_in, ref1_in, ref0_present, ref1_present, active_sel, active_valid;
  logic             backup_valid, backup_aligned, holdover, switch_pulse, sel_valid;
  logic [SEL_W-1:0] sel_a = 4'h0;
  logic [SEL_W-1:0] sel_b = 4'h0;
  logic [SEL_W-1:0] sel_y = 4'h0;
  logic             ovr_a_en = 1'h0;
  logic             ovr_b_en = 1'h0;
  logic             ovr_y_en = 1'h0;
  logic [DIV_W-1:0] ovr_a_val = 16'h0000;
  logic [DIV_W-1:0] ovr_b_val = 16'h0000;
  logic [DIV_W-1:0] ovr_y_val = 16'h0000;
  logic [DIV_W-1:0] div_a, div_b, div_y;
  int               n_errors = 0;
  int               total_checks = 0;
  int               n_sw = 0;
  rsc_note_t        q[$];
  event             obs_ev;
  always #5 clk = ~clk;
  rsc_ref_src u_src (.en0(en0), .en1(en1), .ref0_in(ref0_in), .ref1_in(ref1_in));
  rsc_switchover #(.LOSS_CYCLES(20), .ALIGN_CYCLES(4)) u_dut (.*);
  always @(posedge clk) if (rst_b && switch_pulse === 1'h1) n_sw++;
  function automatic logic [48:0] stat();
    stat = {40'h0, 2'(n_sw), ref0_present, ref1_present, active_sel, active_valid,
            backup_valid, backup_aligned, holdover};
  endfunction
  function automatic logic [48:0] expd();
    logic [15:0] a, b, y;
    a = ovr_a_en ? ovr_a_val : {12'h000, sel_a} + 16'h0001;
    b = ovr_b_en ? ovr_b_val : {12'h000, sel_b} + 16'h0001;
    y = ovr_y_en ? ovr_y_val : {11'h000, sel_y, 1'h0} + 16'h0002;
    expd = {a, b, y, (sel_a != 4'hF || ovr_a_en) && (sel_b != 4'hF || ovr_b_en)};
  endfunction
  task automatic check(input logic [48:0] seen, input logic [48:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // bounded wait for the status to settle, then leave a note for the watcher
  task automatic step(input logic e0, input logic e1, input logic [8:0] exp, input logic [8:0] m);
    int i;
    en0 = e0;
    en1 = e1;
    for (i = 0; i < 300 && (stat() & 49'(m)) !== 49'(exp & m); i++) @(negedge clk);
    if (i == 300) begin
      n_errors++;
      results();
    end
    // let the status stand a while so a flag that flickers is caught
    repeat (40) @(negedge clk);
    q.push_back('{1'h0, 49'(m), 49'(exp & m)});
    -> obs_ev;
    @(negedge clk);
  endtask
  always @(obs_ev) begin
    rsc_note_t n;
    n = q.pop_front();
    check((n.k ? {div_a, div_b, div_y, sel_valid} : stat()) & n.m, n.v);
  end
  initial begin
    void'($urandom(921));
    repeat (20) @(negedge clk);
    rst_b = 1'h1;
    step(1'h0, 1'h0, 9'h000, 9'h1FF);
    step(1'h1, 1'h0, 9'h048, 9'h1FF);
    step(1'h1, 1'h1, 9'h06E, 9'h1FF);
    step(1'h0, 1'h1, 9'h0B8, 9'h1FF);
    step(1'h1, 1'h1, 9'h0FE, 9'h1FF);
    step(1'h0, 1'h1, 9'h0B8, 9'h1FF);
    step(1'h0, 1'h0, 9'h081, 9'h1EF);
    step(1'h0, 1'h1, 9'h0B8, 9'h1FF);
    // the first pass hits the reserved input code with no override
    for (int k = 0; k < 40; k++) begin
      {sel_a, sel_b, sel_y} = (k == 0) ? 12'hF00 : 12'($urandom);
      {ovr_a_en, ovr_b_en, ovr_y_en} = (k == 0) ? 3'h0 : 3'($urandom);
      {ovr_a_val, ovr_b_val, ovr_y_val} = 48'({$urandom, $urandom});
      repeat (2) @(negedge clk);
      q.push_back('{1'h1, {49{1'h1}}, expd()});
      -> obs_ev;
    end
    @(negedge clk);
    results();
  end
endmodule
`default_nettype wire

// file: verification/rsc_ref_src.sv
// partner model: two reference clock sources that park low when stopped
`timescale 1ns/1ns
`default_nettype none
module rsc_ref_src #(
  parameter int HALF0 = 7,
  parameter int HALF1 = 11
) (
  input  wire logic en0,
  input  wire logic en1,
  output var logic  ref0_in,
  output var logic  ref1_in
);
  initial ref0_in = 1'h0;
  initial ref1_in = 1'h0;
  // a dead source gives no edges at all, so loss must come from the timeout
  always #HALF0 ref0_in = en0 ? ~ref0_in : 1'h0;
  always #HALF1 ref1_in = en1 ? ~ref1_in : 1'h0;
endmodule
`default_nettype wire

// file: verification/rsc_switchover_chk.sv
// assertion checker for the reference switchover top
`timescale 1ns/1ns
`default_nettype none
module rsc_switchover_chk
  import rsc_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst_b,
  input wire logic             ref0_present,
  input wire logic             ref1_present,
  input wire logic             active_sel,
  input wire logic             active_valid,
  input wire logic             backup_valid,
  input wire logic             backup_aligned,
  input wire logic             holdover,
  input wire logic             switch_pulse,
  input wire logic [SEL_W-1:0] sel_a,
  input wire logic [SEL_W-1:0] sel_b,
  input wire logic [SEL_W-1:0] sel_y,
  input wire logic             ovr_a_en,
  input wire logic             ovr_b_en,
  input wire logic             ovr_y_en,
  input wire logic [DIV_W-1:0] ovr_y_val,
  input wire logic [DIV_W-1:0] div_y,
  input wire logic             sel_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // presence and selection flags move on the same edge, so look back one cycle
  property p_lone;
    $rose(ref0_present) && !ref1_present && !$past(active_valid)
      |-> ##[0:3] active_valid && !active_sel;
  endproperty
  a_lone: assert property (p_lone) else $error("lone reference not made active");
  property p_both;
    (ref0_present && ref1_present) [*4] |-> active_valid && backup_valid;
  endproperty
  a_both: assert property (p_both) else $error("no backup with both present");
  property p_fresh;
    $rose(backup_valid) |-> !backup_aligned;
  endproperty
  a_fresh: assert property (p_fresh) else $error("new backup flagged aligned");
  property p_swap;
    $past(active_valid) &&
      ((!$past(active_sel) && $fell(ref0_present) && ref1_present) ||
       ($past(active_sel) && $fell(ref1_present) && ref0_present))
      |-> ##[0:3] switch_pulse;
  endproperty
  a_swap: assert property (p_swap) else $error("no switchover to backup");
  property p_pulse;
    switch_pulse |=> !switch_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("switch pulse too long");
  property p_hold;
    $past(active_valid) && !ref0_present && !ref1_present
      |-> ##[0:3] holdover && !active_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("holdover not entered");
  property p_leave;
    $past(holdover) && ref1_present && !ref0_present
      |-> ##[0:3] active_valid && active_sel && !holdover;
  endproperty
  a_leave: assert property (p_leave) else $error("holdover not left");
  property p_preset;
    $past(rst_b) && !$past(ovr_y_en)
      |-> div_y == {11'h000, $past(sel_y), 1'h0} + 16'h0002;
  endproperty
  a_preset: assert property (p_preset) else $error("output preset wrong");
  property p_ovr; $past(rst_b) && $past(ovr_y_en) |-> div_y == $past(ovr_y_val); endproperty
  a_ovr: assert property (p_ovr) else $error("override not applied");
  property p_code; $past(rst_b) |-> sel_valid == (($past(sel_a) != 4'hF || $past(ovr_a_en))
    && ($past(sel_b) != 4'hF || $past(ovr_b_en))); endproperty
  a_code: assert property (p_code) else $error("code validity wrong");
  c_swap: cover property (switch_pulse);
  c_hold: cover property (holdover);
  c_bad: cover property (!sel_valid);
  c_align: cover property (backup_aligned);
endmodule
bind rsc_switchover rsc_switchover_chk u_chk (.*);
`default_nettype wire
